// file: pkg/gcs_consts.vh
// constants for the gauge coil scan start control block
`ifndef GCS_CONSTS_VH
`define GCS_CONSTS_VH
// register byte offsets
`define GCS_CTRL_OFF      8'h00
`define GCS_MASK_OFF      8'h04
`define GCS_STAT_OFF      8'h08
`define GCS_CMR_PAGE      2'h1
`define GCS_CDR_PAGE      2'h2
// coil index field of a buffer address and the page above it
`define GCS_IDX_LO        2
`define GCS_IDX_HI        5
`define GCS_PAGE_LO       6
`define GCS_PAGE_HI       7
`define GCS_DIR_BIT       0
`define GCS_STAT_W        5
// control register fields
`define GCS_TRIG_BIT      0
`define GCS_AUTO_BIT      1
`define GCS_DIV_LO        2
`define GCS_DIV_HI        3
`define GCS_SYNC_POINT_FLAG_BIT      4
`define GCS_SYNC_FLAG_CLEAR_BIT      5
// address decode kinds
`define GCS_K_NONE        3'h0
`define GCS_K_CTRL        3'h1
`define GCS_K_MASK        3'h2
`define GCS_K_STAT        3'h3
`define GCS_K_CMR         3'h4
`define GCS_K_CDR         3'h5
// sequencer figures
`define GCS_NCOIL         12
`define GCS_FIRST_COIL    4'h0
`define GCS_SYNC_COIL     4'ha
`define GCS_LAST_COIL     4'hb
`define GCS_DIV0_M1       12'h1ff
`define GCS_DIV1_M1       12'h3ff
`define GCS_DIV2_M1       12'h7ff
`define GCS_DIV3_M1       12'hfff
`define GCS_MAG_W         8
`define GCS_MASK_W        6
// reset values
`define GCS_MAG_RST       8'h00
`define GCS_MASK_RST      6'h00
`define GCS_DIV_RST       2'h0
// axi responses
`define GCS_RESP_OKAY     2'h0
`define GCS_RESP_SLVERR   2'h2
`endif

// file: design/gcs_scan_ctrl.v
// scan start, mode select and coil sequencer with axi4-lite registers
`timescale 1ns/1ps
`include "gcs_consts.vh"

module gcs_scan_ctrl (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // shared coil drive path
  output wire [7:0]  dac_mag,
  output wire [3:0]  coil_sel,
  output wire        coil_dir,
  output wire        coil_drive_on,
  output wire        coil_update
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SCAN = 1'b1;

  // decode a byte address into a register kind
  function [2:0] addr_kind;
    input [7:0] a;
    begin
      if (a == `GCS_CTRL_OFF)
        addr_kind = `GCS_K_CTRL;
      else if (a == `GCS_MASK_OFF)
        addr_kind = `GCS_K_MASK;
      else if (a == `GCS_STAT_OFF)
        addr_kind = `GCS_K_STAT;
      else if (a[`GCS_PAGE_HI:`GCS_PAGE_LO] == `GCS_CMR_PAGE && a[`GCS_IDX_LO-1:0] == 2'h0 &&
               a[`GCS_IDX_HI:`GCS_IDX_LO] <= `GCS_LAST_COIL)
        addr_kind = `GCS_K_CMR;
      else if (a[`GCS_PAGE_HI:`GCS_PAGE_LO] == `GCS_CDR_PAGE && a[`GCS_IDX_LO-1:0] == 2'h0 &&
               a[`GCS_IDX_HI:`GCS_IDX_LO] <= `GCS_LAST_COIL)
        addr_kind = `GCS_K_CDR;
      else
        addr_kind = `GCS_K_NONE;
    end
  endfunction

  // prescaler terminal count for each divider setting
  function [11:0] div_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    div_limit = `GCS_DIV0_M1;
        2'h1:    div_limit = `GCS_DIV1_M1;
        2'h2:    div_limit = `GCS_DIV2_M1;
        default: div_limit = `GCS_DIV3_M1;
      endcase
    end
  endfunction

  // bus state
  reg        awready_q;
  reg        wready_q;
  reg        aw_got_q;
  reg        w_got_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        bvalid_q;
  reg [1:0]  bresp_q;
  reg        arready_q;
  reg        rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0]  rresp_q;
  // control state
  reg        trig_q;
  reg        auto_q;
  reg [1:0]  div_sel_q;
  reg        sync_q;
  reg        sync_seen_q;
  reg [5:0]  mask_q;
  reg        state_q;
  reg [3:0]  coil_q;
  reg [11:0] presc_q;
  // coil buffers
  reg [7:0]  mag_m [0:`GCS_NCOIL-1];
  reg [7:0]  mag_s [0:`GCS_NCOIL-1];
  reg        dir_m [0:`GCS_NCOIL-1];
  reg        dir_s [0:`GCS_NCOIL-1];
  // drive outputs
  reg [7:0]  dac_mag_q;
  reg [3:0]  coil_sel_q;
  reg        coil_dir_q;
  reg        drive_on_q;
  reg        update_q;

  wire       wr_go = aw_got_q & w_got_q & ~bvalid_q;
  wire [2:0] wr_kind = addr_kind(awaddr_q);
  wire [2:0] rd_kind = addr_kind(s_axi_araddr);
  wire [3:0] wr_idx = awaddr_q[`GCS_IDX_HI:`GCS_IDX_LO];
  wire       ctrl_wr = wr_go & (wr_kind == `GCS_K_CTRL) & wstrb_q[0];
  wire       ar_fire = s_axi_arvalid & arready_q;

  // a trigger write only counts in manual mode with the bit already clear
  wire       trig_set = ctrl_wr & wdata_q[`GCS_TRIG_BIT] & ~auto_q & ~trig_q;

  // sequencer slot timing
  wire       tick = (state_q == ST_SCAN) & (presc_q == div_limit(div_sel_q));
  wire       idle_go = (state_q == ST_IDLE) & (auto_q | trig_q);
  wire       scan_end = tick & (coil_q == `GCS_LAST_COIL);
  wire       again = auto_q | trig_q;
  wire       slot_start = idle_go | (tick & ~(scan_end & ~again));
  wire [3:0] coil_next = (idle_go | scan_end) ? `GCS_FIRST_COIL : coil_q + 4'h1;
  wire       at_sync = slot_start & (coil_next == `GCS_SYNC_COIL);
  // automatic mode refreshes each slave as its slot begins
  wire       auto_copy = slot_start & auto_q;

  // write channel handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `GCS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_got_q  <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        // status is read-only, so a write to it is refused like a hole
        bresp_q  <= (wr_kind == `GCS_K_NONE || wr_kind == `GCS_K_STAT) ?
                    `GCS_RESP_SLVERR : `GCS_RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `GCS_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rresp_q   <= `GCS_RESP_OKAY;
        rdata_q   <= 32'h0000_0000;
        case (rd_kind)
          `GCS_K_CTRL: begin
            rdata_q[`GCS_TRIG_BIT]           <= trig_q;
            rdata_q[`GCS_AUTO_BIT]           <= auto_q;
            rdata_q[`GCS_DIV_HI:`GCS_DIV_LO] <= div_sel_q;
            rdata_q[`GCS_SYNC_POINT_FLAG_BIT]           <= sync_q;
          end
          `GCS_K_MASK: rdata_q[`GCS_MASK_W-1:0] <= mask_q;
          `GCS_K_STAT: rdata_q[`GCS_STAT_W-1:0] <= {state_q, coil_q};
          `GCS_K_CMR:  rdata_q[`GCS_MAG_W-1:0] <= mag_m[s_axi_araddr[`GCS_IDX_HI:`GCS_IDX_LO]];
          `GCS_K_CDR:  rdata_q[`GCS_DIR_BIT] <= dir_m[s_axi_araddr[`GCS_IDX_HI:`GCS_IDX_LO]];
          default:     rresp_q <= `GCS_RESP_SLVERR;
        endcase
      end
      if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // control register, mask and flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_q      <= 1'b0;
      auto_q      <= 1'b0;
      div_sel_q   <= `GCS_DIV_RST;
      sync_q      <= 1'b0;
      sync_seen_q <= 1'b0;
      mask_q      <= `GCS_MASK_RST;
    end else begin
      if (ctrl_wr) begin
        auto_q    <= wdata_q[`GCS_AUTO_BIT];
        // the top setting is still honoured; keeping off it is software's job
        div_sel_q <= wdata_q[`GCS_DIV_HI:`GCS_DIV_LO];
      end
      if (wr_go && wr_kind == `GCS_K_MASK && wstrb_q[0])
        mask_q <= wdata_q[`GCS_MASK_W-1:0];
      // set wins if both meet: set needs the bit low, the clear at the sync slot does not look at it
      if (trig_set)
        trig_q <= 1'b1;
      else if (at_sync)
        trig_q <= 1'b0;
      // a read that shows the flag set arms the write-one clear
      if (ar_fire && rd_kind == `GCS_K_CTRL && sync_q)
        sync_seen_q <= 1'b1;
      if (at_sync) begin
        sync_q <= 1'b1;
      end else if (ctrl_wr && wdata_q[`GCS_SYNC_FLAG_CLEAR_BIT] && sync_seen_q) begin
        sync_q      <= 1'b0;
        sync_seen_q <= 1'b0;
      end
    end
  end

  // sequencer: twelve equal slots per scan
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      coil_q  <= `GCS_FIRST_COIL;
      presc_q <= 12'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          presc_q <= 12'h000;
          if (idle_go) begin
            state_q <= ST_SCAN;
            coil_q  <= `GCS_FIRST_COIL;
          end
        end
        ST_SCAN: begin
          if (tick) begin
            presc_q <= 12'h000;
            if (scan_end && !again)
              state_q <= ST_IDLE;
            else
              coil_q <= coil_next;
          end else begin
            presc_q <= presc_q + 12'h001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          coil_q  <= `GCS_FIRST_COIL;
          presc_q <= 12'h000;
        end
      endcase
    end
  end

  // master and slave buffers, one set per coil
  genvar gi;
  generate
    for (gi = 0; gi < `GCS_NCOIL; gi = gi + 1) begin : g_coil
      always @(posedge aclk) begin
        if (!aresetn) begin
          mag_m[gi] <= `GCS_MAG_RST;
          dir_m[gi] <= 1'b0;
          mag_s[gi] <= `GCS_MAG_RST;
          dir_s[gi] <= 1'b0;
        end else begin
          if (wr_go && wr_kind == `GCS_K_CMR && wr_idx == gi && wstrb_q[0])
            mag_m[gi] <= wdata_q[`GCS_MAG_W-1:0];
          if (wr_go && wr_kind == `GCS_K_CDR && wr_idx == gi && wstrb_q[0])
            dir_m[gi] <= wdata_q[`GCS_DIR_BIT];
          if (trig_set || (auto_copy && coil_next == gi)) begin
            mag_s[gi] <= mag_m[gi];
            dir_s[gi] <= dir_m[gi];
          end
        end
      end
    end
  endgenerate

  // shared drive path: magnitude and polarity are separate fields
  always @(posedge aclk) begin
    if (!aresetn) begin
      dac_mag_q  <= `GCS_MAG_RST;
      coil_sel_q <= `GCS_FIRST_COIL;
      coil_dir_q <= 1'b0;
      drive_on_q <= 1'b0;
      update_q   <= 1'b0;
    end else begin
      update_q <= slot_start;
      if (slot_start) begin
        coil_sel_q <= coil_next;
        // automatic mode drives the value being copied in the same slot
        dac_mag_q  <= auto_copy ? mag_m[coil_next] : mag_s[coil_next];
        coil_dir_q <= auto_copy ? dir_m[coil_next] : dir_s[coil_next];
        // a masked gauge keeps its slot but its driver stays off
        drive_on_q <= mask_q[coil_next[3:1]];
      end else if (scan_end) begin
        drive_on_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign dac_mag       = dac_mag_q;
  assign coil_sel      = coil_sel_q;
  assign coil_dir      = coil_dir_q;
  assign coil_drive_on = drive_on_q;
  assign coil_update   = update_q;

endmodule // gcs_scan_ctrl

// file: testbench/gcs_scan_asserts.sv
// port assertions for the scan start controller
`timescale 1ns/1ps
module gcs_scan_asserts (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // register bus
  input wire       s_axi_awready,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  // coil path
  input wire [3:0] coil_sel,
  input wire       coil_update
);
  reg [12:0] gap_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // saturates so a long idle gap can never wrap into a legal slot length
  always @(posedge aclk)
    if (!aresetn || coil_update) gap_q <= 13'h1;
    else if (gap_q != 13'h1fff) gap_q <= gap_q + 13'h1;
  a_bvalid_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted while response pending");
  a_bvalid_blocks_w: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("write data accepted while response pending");
  a_rvalid_blocks_ar: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_rresp_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  a_update_pulse: assert property (coil_update |=> !coil_update)
    else $error("slot marker longer than one cycle");
  a_coil_range: assert property (coil_update |-> coil_sel <= 4'hb)
    else $error("coil index out of range");
  a_coil_order: assert property (coil_update && coil_sel != 4'h0 |->
    coil_sel == $past(coil_sel) + 4'h1) else $error("coil order broken");
  a_slot_length: assert property (coil_update && coil_sel != 4'h0 |->
    gap_q inside {13'h200, 13'h400, 13'h800, 13'h1000}) else $error("slot length wrong");
endmodule // gcs_scan_asserts

bind gcs_scan_ctrl gcs_scan_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_wready(s_axi_wready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .coil_sel(coil_sel), .coil_update(coil_update));

// file: testbench/gcs_coil_model.sv
// coil driver model: latches what each slot drives into its coil
`timescale 1ns/1ps
module gcs_coil_model (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // shared drive path
  input  wire  [7:0] dac_mag,
  input  wire  [3:0] coil_sel,
  input  wire        coil_dir,
  input  wire        coil_drive_on,
  input  wire        coil_update,
  // held coil state
  output logic [7:0] mag [12],
  output logic       dir [12],
  output logic       on  [12],
  output logic [7:0] cnt
);
  // a pure sink: the drivers never answer, so the model cannot stall the sequencer
  always @(posedge aclk)
    if (!aresetn) cnt <= 8'h0;
    else if (coil_update) begin
      cnt           <= cnt + 8'h1;
      mag[coil_sel] <= dac_mag;
      dir[coil_sel] <= coil_dir;
      on[coil_sel]  <= coil_drive_on;
    end
endmodule // gcs_coil_model

// file: testbench/gauge_coil_scan_start_control_tb.sv
// self-checking bench for the scan start controller
`timescale 1ns/1ps
module gauge_coil_scan_start_control_tb;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [1:0] br; logic [31:0] rd;
                  logic [1:0] rr;} gcs_row_t;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, bready, rready;
  logic [7:0]  awaddr, araddr, cnt;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, cdir, con, cupd;
  logic [7:0]  cmag, mag [12];
  logic [3:0]  csel;
  logic        dir [12], on [12];
  int          num_errors, n_compared, k, c;
  gcs_row_t rows[7] = '{'{8'h04, 32'h3f, 2'h0, 32'h3f, 2'h0}, '{8'h40, 32'ha5, 2'h0, 32'ha5, 2'h0},
    '{8'h8c, 32'h1, 2'h0, 32'h1, 2'h0}, '{8'h00, 32'h8, 2'h0, 32'h8, 2'h0},
    '{8'h08, 32'h1, 2'h2, 32'h0, 2'h0}, '{8'hfc, 32'h1, 2'h2, 32'h0, 2'h2},
    '{8'h70, 32'h1, 2'h2, 32'h0, 2'h2}};

  gcs_scan_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dac_mag(cmag), .coil_sel(csel),
    .coil_dir(cdir), .coil_drive_on(con), .coil_update(cupd));
  gcs_coil_model u_coils (.aclk(aclk), .aresetn(aresetn), .dac_mag(cmag), .coil_sel(csel),
    .coil_dir(cdir), .coil_drive_on(con), .coil_update(cupd), .mag(mag), .dir(dir),
    .on(on), .cnt(cnt));

  always #5 aclk = ~aclk;

  task automatic chk(input [31:0] g, input [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask

  // bready is held high throughout, which the bus allows and avoids a same-edge re-raise
  task automatic wr(input [7:0] a, input [31:0] v);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bvalid, 1'b1);
    r = bresp;
  endtask

  task automatic rd(input [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rvalid, 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic wupd(input int n);
    int t;
    t = 0;
    while (cnt < n && t < 20000) begin
      @(posedge aclk);
      t++;
    end
    chk(cnt >= n, 1'b1);
  endtask

  task automatic results;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    {aclk, aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    {bready, rready} = 2'h3;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00); chk(d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w); chk(r, rows[i].br);
      rd(rows[i].a); chk(d, rows[i].rd); chk(r, rows[i].rr);
    end
    for (int i = 0; i < 12; i++) begin
      wr(8'h40 + 8'(4 * i), 32'h10 + 32'(i));
      wr(8'h80 + 8'(4 * i), 32'(i % 2));
    end
    wr(8'h04, 32'h1f);
    wr(8'h00, 32'h1); rd(8'h00); chk(d[0], 1'b1);
    wr(8'h00, 32'h1);
    wupd(11); rd(8'h00); chk(d[5:0], 32'h10);
    wr(8'h00, 32'h20); rd(8'h00); chk(d[5:0], 32'h0);
    wupd(12); repeat (1500) @(posedge aclk);
    chk(cnt, 32'd12);
    rd(8'h08); chk(d[4], 1'b0);
    for (int i = 0; i < 12; i++)
      if (i < 10) chk({on[i], dir[i], mag[i]}, {1'b1, 1'(i % 2), 8'h10 + 8'(i)});
      else chk(on[i], 1'b0);
    wr(8'h80, 32'h1);
    wr(8'h00, 32'h6); wupd(14);
    c = cnt; k = 0;
    while (cnt == c && k < 5000) begin @(posedge aclk); k++; end
    c = cnt; k = 0;
    while (cnt == c && k < 5000) begin @(posedge aclk); k++; end
    chk(k, 32'd1024);
    wr(8'h00, 32'h7); rd(8'h00); chk(d[1:0], 32'h2);
    wupd(28); chk({dir[0], mag[0]}, {1'b1, 8'h10});
    wr(8'h00, 32'h4); repeat (13000) @(posedge aclk);
    c = cnt; repeat (1500) @(posedge aclk);
    chk(cnt, c);
    // reset in mid-scan: drive path and control must come back idle
    wr(8'h00, 32'h2); repeat (700) @(posedge aclk);
    aresetn <= 1'b0; repeat (2) @(posedge aclk);
    aresetn <= 1'b1; @(posedge aclk);
    chk({con, cupd, csel, cmag}, 32'h0); rd(8'h00); chk(d, 32'h0);
    results;
  end

  initial begin
    repeat (70000) @(posedge aclk);
    num_errors++;
    results;
  end
endmodule // gauge_coil_scan_start_control_tb
